// File: src/mag_pos_pkg.sv
/*
  Shared constants for the magnetic position decoder: widths, steps and reset values.
  Assumes a single 200 MHz system clock and sensors whose outputs are asynchronous to it.
*/
package mag_pos_pkg;
  localparam int SENSORS = 2;
  localparam int PW_W = 16;
  localparam int POS_W = 16;
  localparam logic [PW_W-1:0] PW_CNT_MAX = 16'hFFFF;
  localparam logic [PW_W-1:0] PW_CNT_RST = 16'h0000;
  localparam logic [POS_W-1:0] POS_RST = 16'h0000;
  localparam logic [POS_W-1:0] STEP_LOW = 16'h0001;
  localparam logic [POS_W-1:0] STEP_HIGH = 16'h000A;
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam logic [SENSORS-1:0] SYNC_RST = 2'h3;
endpackage

// File: src/sensor_sync_if.sv
/*
  Carries the synchronised sensor levels from the synchroniser to the decoder core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface sensor_sync_if;
  logic [mag_pos_pkg::SENSORS-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

// File: src/sensor_sync.sv
/*
  Two-stage synchroniser for each asynchronous sensor output.
  Assumes idle sensors read high, so both stages reset high.
*/
`timescale 1ns/1ps
module sensor_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [mag_pos_pkg::SENSORS-1:0] raw,
  sensor_sync_if.src sync
);
  logic [mag_pos_pkg::SENSORS-1:0] meta_ff;
  logic [mag_pos_pkg::SENSORS-1:0] stable_ff;

  genvar i;
  generate
    for (i = 0; i < mag_pos_pkg::SENSORS; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          meta_ff[i] <= mag_pos_pkg::SYNC_RST[i];
          stable_ff[i] <= mag_pos_pkg::SYNC_RST[i];
        end else begin
          meta_ff[i] <= raw[i]; // R13
          stable_ff[i] <= meta_ff[i]; // R13
        end
      end
    end
  endgenerate

  assign sync.level = stable_ff;

  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (!resetn) // R13
    ##2 (stable_ff == $past(raw, 2)))
    else $error("Synchroniser output is not the input two cycles earlier.");
endmodule

// File: src/magnetic_position_decoder.sv
/*
  Decoder for one or two magnetic switch sensors: open/close sensing by level or edge,
  jog-dial direction, pulse-width speed class and a position counter.
  Assumes push-pull sensor outputs that idle high and are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
// Behaviour
// R1 - Sensor idles high with no field
// R2 - Sensor output low above on-threshold, hysteretic
// R3 - Level mode: low is closed, high open
// R4 - Edge mode: falling closes, rising opens
// R5 - Shared edge event: polarity from current level
// R6 - Pulse width counted in clock cycles
// R7 - Width over threshold low speed, under high
// R8 - First sensor falls first: clockwise
// R9 - Second sensor falls first: anticlockwise
// R10 - Same logic at any magnet count
// R11 - Timer overflow before next edge: low speed
// R12 - Position steps 1 slow, 10 fast
// R13 - Two-stage synchroniser before all sensor logic
module magnetic_position_decoder (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sensor_a,
  input wire logic sensor_b,
  input wire logic edge_mode,
  input wire logic [mag_pos_pkg::PW_W-1:0] pw_threshold,
  output logic position_closed,
  output logic close_event,
  output logic open_event,
  output logic cw_event,
  output logic ccw_event,
  output logic speed_low,
  output logic [mag_pos_pkg::POS_W-1:0] position
);
  typedef enum logic [1:0] {LAST_NONE, LAST_A, LAST_B} last_fall_t;

  sensor_sync_if sync_bus ();

  sensor_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw({sensor_b, sensor_a}),
    .sync(sync_bus.src)
  );

  logic [mag_pos_pkg::SENSORS-1:0] prev_ff;
  logic closed_ff;
  logic close_evt_ff;
  logic open_evt_ff;
  logic cw_ff;
  logic ccw_ff;
  logic speed_low_ff;
  logic [mag_pos_pkg::PW_W-1:0] pw_cnt_ff;
  logic [mag_pos_pkg::POS_W-1:0] pos_ff;
  last_fall_t last_ff;
  last_fall_t nxt_last;
  logic nxt_closed;
  logic nxt_speed_low;
  logic [mag_pos_pkg::PW_W-1:0] nxt_pw_cnt;
  logic [mag_pos_pkg::POS_W-1:0] nxt_pos;

  // Edge detect on the stable stage; a level that changes and returns between two clock samples gives no edge.
  wire [mag_pos_pkg::SENSORS-1:0] lvl = sync_bus.level;
  wire [mag_pos_pkg::SENSORS-1:0] any_edge = lvl ^ prev_ff; // R10
  wire [mag_pos_pkg::SENSORS-1:0] fall = any_edge & ~lvl;
  wire [mag_pos_pkg::SENSORS-1:0] rise = any_edge & lvl;
  wire s_a = lvl[mag_pos_pkg::IDX_A];
  wire edge_a = any_edge[mag_pos_pkg::IDX_A];
  // One shared event per edge; the present level tells which way it went.
  wire close_now = edge_mode && edge_a && !s_a; // R4 R5
  wire open_now = edge_mode && edge_a && s_a; // R4 R5
  // The timer has overflowed once the running width passes the threshold.
  wire pw_over = pw_cnt_ff > pw_threshold; // R7 R11
  wire pw_sat = pw_cnt_ff == mag_pos_pkg::PW_CNT_MAX;
  // Simultaneous falls carry no order and are ignored for direction.
  wire fall_a_only = fall[mag_pos_pkg::IDX_A] && !fall[mag_pos_pkg::IDX_B];
  wire fall_b_only = fall[mag_pos_pkg::IDX_B] && !fall[mag_pos_pkg::IDX_A];
  wire cw_now = fall_b_only && (last_ff == LAST_A); // R8
  wire ccw_now = fall_a_only && (last_ff == LAST_B); // R9
  // An edge of the first sensor ends a width, which then decides alone; elsewhere the
  // last class or a pending overflow decides.
  wire slow_now = pw_over || (speed_low_ff && !edge_a); // R11
  wire [mag_pos_pkg::POS_W-1:0] step =
    slow_now ? mag_pos_pkg::STEP_LOW : mag_pos_pkg::STEP_HIGH; // R12

  always_comb begin
    nxt_closed = closed_ff;
    if (!edge_mode) begin
      nxt_closed = !s_a; // R3
    end else if (close_now) begin
      nxt_closed = 1'b1;
    end else if (open_now) begin
      nxt_closed = 1'b0;
    end
  end

  always_comb begin
    nxt_pw_cnt = pw_cnt_ff;
    nxt_speed_low = speed_low_ff;
    if (edge_a) begin
      nxt_pw_cnt = mag_pos_pkg::PW_CNT_RST; // R6
      nxt_speed_low = pw_over; // R7 R11
    end else if (!pw_sat) begin
      nxt_pw_cnt = pw_cnt_ff + 16'h0001; // R6
    end
  end

  always_comb begin
    nxt_last = last_ff;
    if (fall_a_only) begin
      nxt_last = LAST_A;
    end else if (fall_b_only) begin
      nxt_last = LAST_B;
    end
  end

  always_comb begin
    nxt_pos = pos_ff;
    if (cw_now) begin
      nxt_pos = pos_ff + step; // R12
    end else if (ccw_now) begin
      nxt_pos = pos_ff - step; // R12
    end
  end

  // Reset values assume the idle-high sensor, so no edge is seen at release. R1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= mag_pos_pkg::SYNC_RST;
      closed_ff <= 1'b0;
      close_evt_ff <= 1'b0;
      open_evt_ff <= 1'b0;
      cw_ff <= 1'b0;
      ccw_ff <= 1'b0;
      speed_low_ff <= 1'b1;
      pw_cnt_ff <= mag_pos_pkg::PW_CNT_RST;
      pos_ff <= mag_pos_pkg::POS_RST;
      last_ff <= LAST_NONE;
    end else begin
      prev_ff <= lvl;
      closed_ff <= nxt_closed;
      close_evt_ff <= close_now;
      open_evt_ff <= open_now;
      cw_ff <= cw_now;
      ccw_ff <= ccw_now;
      speed_low_ff <= nxt_speed_low;
      pw_cnt_ff <= nxt_pw_cnt;
      pos_ff <= nxt_pos;
      last_ff <= nxt_last;
    end
  end

  assign position_closed = closed_ff;
  assign close_event = close_evt_ff;
  assign open_event = open_evt_ff;
  assign cw_event = cw_ff;
  assign ccw_event = ccw_ff;
  assign speed_low = speed_low_ff;
  assign position = pos_ff;

  a_level_closed: assert property (@(posedge sys_clk) disable iff (!resetn) // R3
    !edge_mode |=> (position_closed == !$past(s_a)))
    else $error("Level mode closed flag does not follow the inverted level.");

  a_close_on_fall: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    (edge_mode && fall[mag_pos_pkg::IDX_A]) |=> (close_event && position_closed))
    else $error("Falling edge did not give a closing event.");

  a_open_on_rise: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    (edge_mode && rise[mag_pos_pkg::IDX_A]) |=> (open_event && !position_closed))
    else $error("Rising edge did not give an opening event.");

  a_event_polarity: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
    close_event |-> (!$past(s_a) && !open_event))
    else $error("Closing event seen while the level was high.");

  a_open_polarity: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
    open_event |-> ($past(s_a) && !close_event))
    else $error("Opening event seen while the level was low.");

  a_width_restart: assert property (@(posedge sys_clk) disable iff (!resetn) // R6
    (edge_a ##1 !edge_a [*3]) |=> (pw_cnt_ff == 16'h0003))
    else $error("Pulse width counter did not count clocks from the edge.");

  a_speed_low_cls: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    (edge_a && pw_over) |=> speed_low)
    else $error("Overflowed width not classed as low speed.");

  a_speed_high_cls: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    (edge_a && (pw_cnt_ff < pw_threshold)) |=> !speed_low)
    else $error("Short width not classed as high speed.");

  a_cw_order: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (fall_b_only && last_ff == LAST_A) |=> (cw_event && !ccw_event))
    else $error("Clockwise order not reported.");

  a_ccw_order: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    (fall_a_only && last_ff == LAST_B) |=> (ccw_event && !cw_event))
    else $error("Anticlockwise order not reported.");

  a_no_dir_sim: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (fall[mag_pos_pkg::IDX_A] && fall[mag_pos_pkg::IDX_B]) |=> (!cw_event && !ccw_event))
    else $error("Simultaneous falls gave a direction event.");

  a_pos_step: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    cw_event |-> (position == $past(pos_ff) + $past(step)))
    else $error("Position did not step by the speed class amount.");

  a_pos_step_ccw: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    ccw_event |-> (position == $past(pos_ff) - $past(step)))
    else $error("Position did not step down by the speed class amount.");

  a_pos_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    (!cw_event && !ccw_event) |-> $stable(position))
    else $error("Position changed without a direction event.");

  c_close_open: cover property (@(posedge sys_clk) disable iff (!resetn)
    close_event ##[1:50] open_event);
  c_cw_fast: cover property (@(posedge sys_clk) disable iff (!resetn)
    cw_event && !speed_low);
  c_ccw_slow: cover property (@(posedge sys_clk) disable iff (!resetn)
    ccw_event && speed_low);
  c_level_closed: cover property (@(posedge sys_clk) disable iff (!resetn)
    !edge_mode && position_closed);
endmodule

// File: dv/mag_sensor_model.sv
/*
  Behavioural model of one magnetic switch sensor with a push-pull output.
  Assumes the bench sets the flux level; thresholds are plain defaults.
*/
`timescale 1ns/1ps
module mag_sensor_model #(
  parameter int ON_LVL = 60,
  parameter int OFF_LVL = 40
) (
  input wire logic [7:0] flux,
  output logic level
);
  initial level = 1'b1;
  // Between the two thresholds the output keeps its last state.
  always @(flux) begin
    if (flux >= ON_LVL) begin
      level = 1'b0;
    end else if (flux <= OFF_LVL) begin
      level = 1'b1;
    end
  end
endmodule

// File: dv/magnetic_position_decoder_bench.sv
/*
  Self-checking bench for the magnetic position decoder.
  Assumes two sensor models on sensor_a and sensor_b and a 200 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module magnetic_position_decoder_bench;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic edge_mode = 1'b0;
  logic [15:0] pw_threshold = 16'h0004;
  logic [7:0] flux_a = 8'h00;
  logic [7:0] flux_b = 8'h00;
  logic sensor_a, sensor_b, position_closed, close_event, open_event;
  logic cw_event, ccw_event, speed_low;
  logic [15:0] position;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_close = 0, n_open = 0, n_cw = 0, n_ccw = 0;

  always #2.5 sys_clk = ~sys_clk;

  mag_sensor_model u_sens_a (.flux(flux_a), .level(sensor_a));
  mag_sensor_model u_sens_b (.flux(flux_b), .level(sensor_b));

  magnetic_position_decoder u_dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sensor_a(sensor_a),
    .sensor_b(sensor_b),
    .edge_mode(edge_mode),
    .pw_threshold(pw_threshold),
    .position_closed(position_closed),
    .close_event(close_event),
    .open_event(open_event),
    .cw_event(cw_event),
    .ccw_event(ccw_event),
    .speed_low(speed_low),
    .position(position)
  );

  // Event pulses last one cycle, so they are tallied at every edge.
  always @(posedge sys_clk) begin
    cycles++;
    n_close += (close_event === 1'b1);
    n_open += (open_event === 1'b1);
    n_cw += (cw_event === 1'b1);
    n_ccw += (ccw_event === 1'b1);
    if (cycles == 4000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_flux(input logic [7:0] a, input logic [7:0] b, input int n);
    @(posedge sys_clk);
    flux_a <= a;
    flux_b <= b;
    wait_clk(n);
    #1;
  endtask

  task automatic check_reset();
    `CHK("position", mag_pos_pkg::POS_RST, position)
    `CHK("speed_low", 1'b1, speed_low)
    `CHK("closed", 1'b0, position_closed)
  endtask

  task automatic level_test();
    set_flux(8'h50, 8'h00, 6);
    `CHK("closed", 1'b1, position_closed)
    set_flux(8'h32, 8'h00, 6);
    `CHK("closed", 1'b1, position_closed)
    set_flux(8'h14, 8'h00, 6);
    `CHK("closed", 1'b0, position_closed)
    `CHK("close_n", 0, n_close)
  endtask

  task automatic edge_test();
    edge_mode <= 1'b1;
    set_flux(8'h50, 8'h00, 6);
    `CHK("close_n", 1, n_close)
    `CHK("open_n", 0, n_open)
    set_flux(8'h00, 8'h00, 6);
    `CHK("open_n", 1, n_open)
    `CHK("closed", 1'b0, position_closed)
  endtask

  task automatic jog_slow();
    set_flux(8'h50, 8'h00, 20);
    set_flux(8'h50, 8'h50, 6);
    `CHK("cw_n", 1, n_cw)
    `CHK("position", 16'h0001, position)
    `CHK("speed_low", 1'b1, speed_low)
    set_flux(8'h00, 8'h00, 6);
  endtask

  task automatic jog_fast();
    pw_threshold <= 16'h0100;
    set_flux(8'h00, 8'h50, 5);
    set_flux(8'h50, 8'h50, 6);
    `CHK("ccw_n", 1, n_ccw)
    `CHK("position", 16'hfff7, position)
    `CHK("speed_low", 1'b0, speed_low)
    set_flux(8'h00, 8'h00, 6);
    set_flux(8'h50, 8'h00, 4);
    set_flux(8'h50, 8'h50, 6);
    `CHK("cw_n", 2, n_cw)
    `CHK("position", 16'h0001, position)
  endtask

  task automatic sim_fall_test();
    set_flux(8'h00, 8'h00, 6);
    set_flux(8'h50, 8'h50, 6);
    `CHK("cw_n", 2, n_cw)
    `CHK("ccw_n", 1, n_ccw)
    `CHK("position", 16'h0001, position)
  endtask

  initial begin
    wait_clk(20);
    resetn <= 1'b1;
    wait_clk(2);
    #1;
    check_reset();
    level_test();
    edge_test();
    jog_slow();
    jog_fast();
    sim_fall_test();
    finish_test();
  end
endmodule
